// ===== fslr_pkg.sv
// shared constants for the flash security and lockout recovery block
package fslr_pkg;
	localparam int IR_W = 4;
	localparam int ID_W = 32;
	localparam int DIV_W = 7;
	localparam int DIV_FIELD_W = 6;
	localparam int PRESCALE_BIT = 6;
	localparam int CNT_W = 11;

	// instruction codes of the test access port
	localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
	localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
	localparam logic [IR_W-1:0] IR_DEBUG = 4'h7;
	localparam logic [IR_W-1:0] IR_LOCKOUT_RECOVERY = 4'hb;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RESET_VAL = IR_IDCODE;

	// identification value is arbitrary
	localparam logic [ID_W-1:0] IDCODE_VAL = 32'h1234_5001;

	// security word built from the two security bytes; any other value is unsecured
	localparam logic [15:0] SEC_WORD = 16'h5aa5;

	// flash input clock is the system clock divided by two
	localparam int FLASH_IN_DIV = 2;
	localparam int PRESCALE_DIV = 8;
	localparam logic [DIV_W-1:0] DIV_RESET_VAL = 7'h00;
endpackage

// ===== fslr_erase_clk_div.sv
// timed-event clock divider for the flash erase algorithm
`timescale 1ns/1ps
`default_nettype none
module fslr_erase_clk_div (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          clk_en,
	// run enable and divider setting
	input  wire logic                          run,
	input  wire logic [fslr_pkg::DIV_W-1:0]    divider,
	// timed event tick
	output logic                               tick_r
);
	logic [fslr_pkg::CNT_W-1:0] cnt_r;
	logic [fslr_pkg::CNT_W-1:0] cnt_nxt;
	logic                       tick_nxt;

	// sys_clk cycles per tick: 2 * (8 if prescaled) * (div + 1)
	function automatic logic [fslr_pkg::CNT_W-1:0] period(input logic [fslr_pkg::DIV_W-1:0] d);
		logic [fslr_pkg::CNT_W-1:0] base;
		base = fslr_pkg::CNT_W'(d[fslr_pkg::DIV_FIELD_W-1:0]) + 11'h001;
		base = fslr_pkg::CNT_W'(base * fslr_pkg::FLASH_IN_DIV);
		if (d[fslr_pkg::PRESCALE_BIT]) begin
			base = fslr_pkg::CNT_W'(base * fslr_pkg::PRESCALE_DIV);
		end
		return base;
	endfunction

	always_comb begin
		cnt_nxt = 11'h000;
		tick_nxt = 1'b0;
		if (run) begin
			if (cnt_r >= period(divider) - 11'h001) begin
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 11'h001;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (clk_en) begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ticks never come back to back
	a_tick_spacing: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		tick_r |=> !tick_r) else $error("erase clock ticks back to back");
endmodule
`default_nettype wire

// ===== fslr_top.sv
// flash security interlock with jtag lockout recovery
// How it works
// - security comes only from non-volatile bytes
// - exactly two bytes decide security
// - secured turns the on-chip debug port off
// - boot picks unsecured or secure mode
// - tap, boundary scan, idcode work always
// - read inhibit follows security bytes at reset
// - recovery mass-erases flash, clearing security
// - recovery instruction selects 7-bit divider register
// - jtag divider replaces flash clock divider
// - bit 6 prescale, bits 5:0 divisor
// - erase runs while tap stays in idle
// - backdoor key works only when enabled
`timescale 1ns/1ps
`default_nettype none
module fslr_top #(
	parameter int BSR_W = 8
) (
	// clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       sys_rst,
	input  wire logic                       clk_en,
	// jtag pins, sampled on sys_clk
	input  wire logic                       jtag_tck,
	input  wire logic                       jtag_tms,
	input  wire logic                       jtag_tdi,
	input  wire logic                       jtag_trst_n,
	output logic                            jtag_tdo_r,
	output logic                            jtag_tdo_oe_r,
	// flash configuration field
	input  wire logic [7:0]                 sec_byte_hi,
	input  wire logic [7:0]                 sec_byte_lo,
	input  wire logic                       backdoor_key_enable,
	input  wire logic                       backdoor_key_match,
	// boundary scan pin values
	input  wire logic [BSR_W-1:0]           bsr_pins,
	output logic [BSR_W-1:0]                bsr_drive_r,
	// flash module control
	input  wire logic [fslr_pkg::DIV_W-1:0] flash_clock_divider_reg,
	input  wire logic                       flash_erase_done,
	output logic                            flash_mass_erase_r,
	output logic [fslr_pkg::DIV_W-1:0]      flash_divider_r,
	output logic                            flash_timed_tick_r,
	// security state
	output logic                            secure_mode_r,
	output logic                            debug_read_inhibit_r,
	output logic                            onchip_debug_port_en_r,
	output logic                            recovery_done_r
);
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
		TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
		TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
		TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
	} fslr_tap_t;

	fslr_tap_t                       tap_r, tap_nxt;
	logic                            tck_q_r;
	logic [fslr_pkg::IR_W-1:0]       ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
	logic [fslr_pkg::ID_W-1:0]       id_sh_r, id_sh_nxt;
	logic                            byp_r, byp_nxt;
	logic [BSR_W-1:0]                bsr_sh_r, bsr_sh_nxt, bsr_drive_nxt;
	logic [fslr_pkg::DIV_W-1:0]      rec_sh_r, rec_sh_nxt, rec_div_r, rec_div_nxt;
	logic                            rec_loaded_r, rec_loaded_nxt;
	logic                            tdo_nxt, tdo_oe_nxt;
	logic                            tck_rise, tck_fall;

	assign tck_rise = jtag_tck & ~tck_q_r;
	assign tck_fall = ~jtag_tck & tck_q_r;

	// tap state and shift registers
	always_comb begin
		tap_nxt = tap_r;
		ir_sh_nxt = ir_sh_r;
		ir_nxt = ir_r;
		id_sh_nxt = id_sh_r;
		byp_nxt = byp_r;
		bsr_sh_nxt = bsr_sh_r;
		bsr_drive_nxt = bsr_drive_r;
		rec_sh_nxt = rec_sh_r;
		rec_div_nxt = rec_div_r;
		rec_loaded_nxt = rec_loaded_r;
		tdo_nxt = jtag_tdo_r;
		tdo_oe_nxt = jtag_tdo_oe_r;
		if (!jtag_trst_n) begin
			// trst forces the tap into reset
			tap_nxt = TAP_RESET;
			ir_nxt = fslr_pkg::IR_RESET_VAL;
			rec_loaded_nxt = 1'b0;
			tdo_oe_nxt = 1'b0;
		end else if (tck_rise) begin
			case (tap_r)
				TAP_RESET:  tap_nxt = jtag_tms ? TAP_RESET : TAP_IDLE;
				TAP_IDLE:   tap_nxt = jtag_tms ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR: tap_nxt = jtag_tms ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR: tap_nxt = jtag_tms ? TAP_EX1_DR : TAP_SH_DR;
				TAP_SH_DR:  tap_nxt = jtag_tms ? TAP_EX1_DR : TAP_SH_DR;
				TAP_EX1_DR: tap_nxt = jtag_tms ? TAP_UPD_DR : TAP_PAU_DR;
				TAP_PAU_DR: tap_nxt = jtag_tms ? TAP_EX2_DR : TAP_PAU_DR;
				TAP_EX2_DR: tap_nxt = jtag_tms ? TAP_UPD_DR : TAP_SH_DR;
				TAP_UPD_DR: tap_nxt = jtag_tms ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_IR: tap_nxt = jtag_tms ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR: tap_nxt = jtag_tms ? TAP_EX1_IR : TAP_SH_IR;
				TAP_SH_IR:  tap_nxt = jtag_tms ? TAP_EX1_IR : TAP_SH_IR;
				TAP_EX1_IR: tap_nxt = jtag_tms ? TAP_UPD_IR : TAP_PAU_IR;
				TAP_PAU_IR: tap_nxt = jtag_tms ? TAP_EX2_IR : TAP_PAU_IR;
				TAP_EX2_IR: tap_nxt = jtag_tms ? TAP_UPD_IR : TAP_SH_IR;
				TAP_UPD_IR: tap_nxt = jtag_tms ? TAP_SEL_DR : TAP_IDLE;
				default:    tap_nxt = TAP_RESET;
			endcase
			case (tap_r)
				TAP_RESET: begin
					ir_nxt = fslr_pkg::IR_RESET_VAL;
					rec_loaded_nxt = 1'b0;
				end
				TAP_CAP_IR: ir_sh_nxt = fslr_pkg::IR_CAPTURE;
				TAP_SH_IR:  ir_sh_nxt = {jtag_tdi, ir_sh_r[fslr_pkg::IR_W-1:1]};
				TAP_UPD_IR: begin
					ir_nxt = ir_sh_r;
					rec_loaded_nxt = 1'b0;
				end
				TAP_CAP_DR: begin
					id_sh_nxt = fslr_pkg::IDCODE_VAL;
					byp_nxt = 1'b0;
					bsr_sh_nxt = bsr_pins;
					rec_sh_nxt = rec_div_r;
				end
				TAP_SH_DR: begin
					id_sh_nxt = {jtag_tdi, id_sh_r[fslr_pkg::ID_W-1:1]};
					byp_nxt = jtag_tdi;
					bsr_sh_nxt = {jtag_tdi, bsr_sh_r[BSR_W-1:1]};
					// the 7-bit divider register shifts in every shift-dr, whatever the instruction
					rec_sh_nxt = {jtag_tdi, rec_sh_r[fslr_pkg::DIV_W-1:1]};
				end
				TAP_UPD_DR: begin
					if (ir_r == fslr_pkg::IR_EXTEST) begin
						bsr_drive_nxt = bsr_sh_r;
					end
					// divider counts as loaded only after an update under recovery
					if (ir_r == fslr_pkg::IR_LOCKOUT_RECOVERY) begin
						rec_div_nxt = rec_sh_r;
						rec_loaded_nxt = 1'b1;
					end
				end
				default: ;
			endcase
		end else if (tck_fall) begin
			// scan chains stay reachable whatever the security state
			tdo_oe_nxt = (tap_r == TAP_SH_DR) || (tap_r == TAP_SH_IR);
			if (tap_r == TAP_SH_IR) begin
				tdo_nxt = ir_sh_r[0];
			end else begin
				case (ir_r)
					fslr_pkg::IR_IDCODE:           tdo_nxt = id_sh_r[0];
					fslr_pkg::IR_EXTEST,
					fslr_pkg::IR_SAMPLE:           tdo_nxt = bsr_sh_r[0];
					fslr_pkg::IR_LOCKOUT_RECOVERY: tdo_nxt = rec_sh_r[0];
					default:                       tdo_nxt = byp_r;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tap_r <= TAP_RESET;
			tck_q_r <= 1'b0;
			ir_sh_r <= '0;
			ir_r <= fslr_pkg::IR_RESET_VAL;
			id_sh_r <= '0;
			byp_r <= 1'b0;
			bsr_sh_r <= '0;
			bsr_drive_r <= '0;
			rec_sh_r <= '0;
			rec_div_r <= fslr_pkg::DIV_RESET_VAL;
			rec_loaded_r <= 1'b0;
			jtag_tdo_r <= 1'b0;
			jtag_tdo_oe_r <= 1'b0;
		end else if (clk_en) begin
			tap_r <= tap_nxt;
			tck_q_r <= jtag_tck;
			ir_sh_r <= ir_sh_nxt;
			ir_r <= ir_nxt;
			id_sh_r <= id_sh_nxt;
			byp_r <= byp_nxt;
			bsr_sh_r <= bsr_sh_nxt;
			bsr_drive_r <= bsr_drive_nxt;
			rec_sh_r <= rec_sh_nxt;
			rec_div_r <= rec_div_nxt;
			rec_loaded_r <= rec_loaded_nxt;
			jtag_tdo_r <= tdo_nxt;
			jtag_tdo_oe_r <= tdo_oe_nxt;
		end
	end

	// security and recovery
	logic                        sampled_r, sampled_nxt;
	logic                        sec_r, sec_nxt;
	logic                        erase_nxt, done_nxt;
	logic [fslr_pkg::DIV_W-1:0]  div_nxt;
	logic                        tick;

	always_comb begin
		sampled_nxt = 1'b1;
		sec_nxt = sec_r;
		if (!sampled_r) begin
			// caught once after reset from the two security bytes only
			sec_nxt = ({sec_byte_hi, sec_byte_lo} == fslr_pkg::SEC_WORD);
		end else if (backdoor_key_enable && backdoor_key_match) begin
			// backdoor unsecure only when the key is enabled
			sec_nxt = 1'b0;
		end
		// erase runs only while the tap sits in idle under recovery
		erase_nxt = rec_loaded_r && (ir_r == fslr_pkg::IR_LOCKOUT_RECOVERY) &&
			(tap_r == TAP_IDLE) && jtag_trst_n && !recovery_done_r;
		// done stays until trst; erased bytes read unsecured at next reset
		done_nxt = recovery_done_r;
		if (flash_mass_erase_r && flash_erase_done) begin
			done_nxt = 1'b1;
		end else if (!jtag_trst_n) begin
			done_nxt = 1'b0;
		end
		// jtag divider maps bit 6 to prescale, 5:0 to divisor
		div_nxt = erase_nxt ? rec_div_r : flash_clock_divider_reg;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sampled_r <= 1'b0;
			sec_r <= 1'b1;
			secure_mode_r <= 1'b1;
			debug_read_inhibit_r <= 1'b1;
			onchip_debug_port_en_r <= 1'b0;
			flash_mass_erase_r <= 1'b0;
			recovery_done_r <= 1'b0;
			flash_divider_r <= fslr_pkg::DIV_RESET_VAL;
		end else if (clk_en) begin
			sampled_r <= sampled_nxt;
			sec_r <= sec_nxt;
			// mode and read inhibit follow the caught security state
			secure_mode_r <= sec_r;
			debug_read_inhibit_r <= sec_r | ~sampled_r;
			onchip_debug_port_en_r <= sampled_r & ~sec_r;
			flash_mass_erase_r <= erase_nxt;
			recovery_done_r <= done_nxt;
			flash_divider_r <= div_nxt;
		end
	end

	// secure until the bytes have been looked at, so no early debug window
	fslr_erase_clk_div u_div (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.run     (flash_mass_erase_r),
		.divider (flash_divider_r),
		.tick_r  (tick)
	);
	assign flash_timed_tick_r = tick;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst || !clk_en);

	sequence s_enter_idle;
		rec_loaded_r && (ir_r == fslr_pkg::IR_LOCKOUT_RECOVERY) && (tap_r == TAP_IDLE);
	endsequence
	sequence s_erase_ok;
		jtag_trst_n && !recovery_done_r;
	endsequence

	a_sec_hold: assert property (sampled_r && !(backdoor_key_enable && backdoor_key_match) |=>
		$stable(sec_r)) else $error("security changed without a reset");
	a_two_bytes: assert property (!sampled_r |=>
		sec_r == ($past({sec_byte_hi, sec_byte_lo}) == fslr_pkg::SEC_WORD)) else $error("bad security decode");
	a_debug_off: assert property (sec_r |=> !onchip_debug_port_en_r) else $error("debug open while secured");
	a_mode_follow: assert property (sampled_r |=> secure_mode_r == $past(sec_r)) else $error("mode wrong");
	a_tap_trst: assert property (!jtag_trst_n |=> tap_r == TAP_RESET ##0 ir_r == fslr_pkg::IR_IDCODE)
		else $error("trst did not reset tap");
	a_inhibit_sec: assert property (sec_r |=> debug_read_inhibit_r) else $error("reads not inhibited");
	a_done_stops: assert property (recovery_done_r |=> !flash_mass_erase_r) else $error("erase after done");
	a_erase_start: assert property (s_enter_idle ##0 s_erase_ok |=> flash_mass_erase_r)
		else $error("erase did not start in idle");
	a_erase_stop: assert property (tap_r != TAP_IDLE |=> !flash_mass_erase_r) else $error("erase outside idle");
	a_div_replace: assert property (flash_mass_erase_r |-> flash_divider_r == rec_div_r)
		else $error("jtag divider not applied");
	a_key_gate: assert property (sampled_r && sec_r && !backdoor_key_enable |=> sec_r)
		else $error("unsecured without key enable");
endmodule
`default_nettype wire

// ===== fslr_jtag_host.sv
// jtag debug host model that drives the test access port pins
`timescale 1ns/1ps
`default_nettype none
module fslr_jtag_host (
	// pacing clock
	input  wire logic sys_clk,
	// jtag pins
	input  wire logic tdo,
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n
);
	logic o_unused;

	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
		trst_n = 1'h0;
	end

	// each tck phase is three sys_clk cycles, above the two-cycle minimum
	task automatic step(input logic t, input logic d, output logic o);
		@(posedge sys_clk);
		#1;
		tms = t;
		tdi = d;
		repeat (2) @(posedge sys_clk);
		#1;
		o = tdo;
		tck = 1'h1;
		repeat (3) @(posedge sys_clk);
		#1;
		tck = 1'h0;
	endtask

	// tdi flips outside shifts so a stale value never passes for data
	task automatic nav(input logic t);
		step(t, ~tdi, o_unused);
	endtask

	task automatic tap_reset();
		@(posedge sys_clk);
		#1;
		trst_n = 1'h0;
		repeat (4) @(posedge sys_clk);
		#1;
		trst_n = 1'h1;
		nav(1'h0);
	endtask

	// scan from idle, lsb first, back to idle
	task automatic scan(input logic ir, input logic [31:0] v, input int n, output logic [31:0] got);
		logic b;
		got = '0;
		nav(1'h1);
		if (ir)
			nav(1'h1);
		nav(1'h0);
		nav(1'h0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], b);
			got[i] = b;
		end
		nav(1'h1);
		nav(1'h0);
	endtask

	// divider loaded first, then tck stands still in idle with tms low
	task automatic recover(input logic [6:0] div);
		logic [31:0] g;
		scan(1'h1, 32'(fslr_pkg::IR_LOCKOUT_RECOVERY), 4, g);
		scan(1'h0, 32'(div), 7, g);
	endtask
endmodule
`default_nettype wire

// ===== fslr_top_tb_top.sv
// self-checking testbench for the flash security and recovery block
`timescale 1ns/1ps
`default_nettype none
module fslr_top_tb_top;
	logic        sys_clk, sys_rst, tck, tms, tdi, trst_n, tdo;
	logic        key_en, key_match, erase_done, erase, tick, secure, inhibit, dbg_en, done;
	logic        clk_en, tdo_oe;
	logic [7:0]  sec_byte_hi, sec_byte_lo, bsr_drive;
	logic [6:0]  fdiv;
	logic [31:0] got;
	int          n_fail = 0;
	int          checks = 0;
	int          cyc = 0;
	int          cnt;
	logic [15:0] words [4] = '{16'h5aa4, 16'h4aa5, 16'hffff, 16'h5aa5};
	// one value per prescale setting, both in the legal flash clock band
	logic [6:0]  divs [2] = '{7'h13, 7'h49};

	fslr_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .jtag_tck(tck),
		.jtag_tms(tms), .jtag_tdi(tdi), .jtag_trst_n(trst_n), .jtag_tdo_r(tdo), .jtag_tdo_oe_r(tdo_oe),
		.sec_byte_hi(sec_byte_hi), .sec_byte_lo(sec_byte_lo), .backdoor_key_enable(key_en),
		.backdoor_key_match(key_match), .bsr_pins(8'h3c), .bsr_drive_r(bsr_drive),
		.flash_clock_divider_reg(7'h2a), .flash_erase_done(erase_done),
		.flash_mass_erase_r(erase), .flash_divider_r(fdiv), .flash_timed_tick_r(tick),
		.secure_mode_r(secure), .debug_read_inhibit_r(inhibit), .onchip_debug_port_en_r(dbg_en),
		.recovery_done_r(done));
	fslr_jtag_host host (.sys_clk(sys_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic rst(input logic [15:0] w);
		@(posedge sys_clk);
		#1;
		{sec_byte_hi, sec_byte_lo} = w;
		sys_rst = 1'h1;
		repeat (6) @(posedge sys_clk);
		#1;
		sys_rst = 1'h0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (tick !== 1'h1 && n < 2000);
	endtask

	// hang guard: the planned run needs well under this many cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			test_done();
		end
	end

	initial begin
		sys_rst = 1'h1;
		clk_en = 1'h1;
		// key inputs settle before the security bytes
		{key_en, key_match, erase_done} = 3'h0;
		{sec_byte_hi, sec_byte_lo} = 16'h5aa5;
		repeat (6) @(posedge sys_clk);
		#1;
		sys_rst = 1'h0;
		foreach (words[i]) begin
			rst(words[i]);
			chk(secure, words[i] === fslr_pkg::SEC_WORD);
			chk(inhibit, words[i] === fslr_pkg::SEC_WORD);
			chk(dbg_en, words[i] !== fslr_pkg::SEC_WORD);
		end
		chk(fdiv, 7'h2a);
		{sec_byte_hi, sec_byte_lo} = 16'hffff;
		repeat (4) @(posedge sys_clk);
		#1;
		chk(secure, 1'h1);
		$display("test boot security done");
		key_match = 1'h1;
		repeat (4) @(posedge sys_clk);
		#1;
		chk(secure, 1'h1);
		// enable low must freeze the key unsecure until it returns
		key_en = 1'h1;
		clk_en = 1'h0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk(secure, 1'h1);
		clk_en = 1'h1;
		repeat (4) @(posedge sys_clk);
		#1;
		chk(secure, 1'h0);
		chk(dbg_en, 1'h1);
		{key_en, key_match} = 2'h0;
		$display("test backdoor key done");
		rst(16'h5aa5);
		host.tap_reset();
		host.scan(1'h1, 32'(fslr_pkg::IR_IDCODE), 4, got);
		chk(got[3:0], fslr_pkg::IR_CAPTURE);
		host.scan(1'h0, 32'h0, 32, got);
		chk(got, fslr_pkg::IDCODE_VAL);
		host.scan(1'h1, 32'(fslr_pkg::IR_SAMPLE), 4, got);
		host.scan(1'h0, 32'h5a, 8, got);
		chk(got[7:0], 8'h3c);
		chk(bsr_drive, 8'h00);
		host.scan(1'h1, 32'(fslr_pkg::IR_EXTEST), 4, got);
		host.scan(1'h0, 32'ha5, 8, got);
		chk(got[7:0], 8'h3c);
		chk(bsr_drive, 8'ha5);
		host.scan(1'h1, 32'(fslr_pkg::IR_DEBUG), 4, got);
		host.scan(1'h0, 32'h1, 2, got);
		chk(got[1:0], 2'h2);
		chk(tdo_oe, 1'h0);
		// park in shift-dr: enable follows the fall one cycle late
		host.nav(1'h1);
		host.nav(1'h0);
		host.nav(1'h0);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(tdo_oe, 1'h1);
		host.nav(1'h1);
		host.nav(1'h1);
		host.nav(1'h0);
		chk(inhibit, 1'h1);
		$display("test secured tap done");
		foreach (divs[i]) begin
			rst(16'h5aa5);
			host.tap_reset();
			host.recover(divs[i]);
			cnt = 0;
			while (erase !== 1'h1 && cnt < 50) begin
				@(posedge sys_clk);
				#1;
				cnt++;
			end
			chk(erase, 1'h1);
			chk(fdiv, divs[i]);
			wait_tick(cnt);
			wait_tick(cnt);
			chk(cnt, fslr_pkg::FLASH_IN_DIV * (divs[i][6] ? fslr_pkg::PRESCALE_DIV : 1) * (divs[i][5:0] + 1));
			erase_done = 1'h1;
			{sec_byte_hi, sec_byte_lo} = 16'hffff;
			@(posedge sys_clk);
			#1;
			erase_done = 1'h0;
			repeat (2) @(posedge sys_clk);
			#1;
			chk(done, 1'h1);
			chk(erase, 1'h0);
			chk(secure, 1'h1);
			host.tap_reset();
			chk(done, 1'h0);
			rst(16'hffff);
			chk(secure, 1'h0);
			chk(dbg_en, 1'h1);
		end
		$display("test lockout recovery done");
		test_done();
	end
endmodule
`default_nettype wire
